// ---- verification/embi_bus_properties.sv ----
// pin checker for the external bus master
`timescale 1ns/1ps
`default_nettype none
module embi_bus_properties (
  input wire logic clock_i, rst_n_i, hold_req_n_i, ready_i, req_valid_i, req_ready_o,
  input wire logic bus_grant_ack_n_o, addr_latch_o, read_strobe_n_o, ctrl_oe_o, addr_oe_o,
  input wire logic [23:0] req_addr_i, addr_o,
  input wire logic [3:0] space_select_n_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  property p_rel; !bus_grant_ack_n_o |-> !ctrl_oe_o && !addr_oe_o; endproperty
  a_rel: assert property (p_rel) else $error("pins driven in hold");
  property p_stay; !bus_grant_ack_n_o && !hold_req_n_i |=> !bus_grant_ack_n_o; endproperty
  a_stay: assert property (p_stay) else $error("hold left early");
  property p_leave; !bus_grant_ack_n_o && hold_req_n_i |=> bus_grant_ack_n_o; endproperty
  a_leave: assert property (p_leave) else $error("ack low after hold");
  property p_gate; req_ready_o |-> hold_req_n_i && bus_grant_ack_n_o; endproperty
  a_gate: assert property (p_gate) else $error("accept during hold");
  property p_take; req_valid_i && req_ready_o |=> addr_latch_o ##1 !addr_latch_o; endproperty
  a_take: assert property (p_take) else $error("latch pulse wrong");
  property p_addr;
    addr_latch_o |-> addr_o == {~$past(req_addr_i[23]), $past(req_addr_i[22:0])};
  endproperty
  a_addr: assert property (p_addr) else $error("address pins wrong");
  property p_cs; addr_latch_o |-> space_select_n_o == ~(4'h1 << $past(req_addr_i[23:22]));
  endproperty
  a_cs: assert property (p_cs) else $error("select wrong");
  property p_wait; !read_strobe_n_o && !ready_i |=> !read_strobe_n_o; endproperty
  a_wait: assert property (p_wait) else $error("wait not kept");
  c_hold: cover property (!bus_grant_ack_n_o);
  c_wait: cover property (!read_strobe_n_o && !ready_i);
  c_take: cover property (addr_latch_o);
endmodule : embi_bus_properties
`default_nettype wire

// ---- verification/embi_bus_tb.sv ----
// testbench for the external bus master
`timescale 1ns/1ps
`default_nettype none
module external_memory_bus_interface_tb_top;
  logic clock_i = 0, rst_n_i = 0, boot_mode_strap_i = 1, byte_width_strap_i = 0;
  logic combined_strobe_sel_i = 0, mux_bus_sel_i = 0, req_valid_i = 0, req_write_i = 0;
  logic hold_req_n_i = 1, req_ready_o, rsp_valid_o, ext_mode_o, bus_grant_ack_n_o, ready_i;
  logic addr_oe_o, low_lane_store_strobe_n_o, high_lane_store_strobe_n_o, read_strobe_n_o;
  logic addr_latch_o, ctrl_oe_o;
  logic [23:0] req_addr_i = 0, addr_o;
  logic [15:0] req_wdata_i = 0, rsp_rdata_o, data_i, data_o, ale_d, rdata;
  logic [1:0] data_oe_o;
  logic [3:0] space_select_n_o, wt = 0;
  logic [2:0] sb;
  int fails = 0, comparisons = 0;
  embi_bus u_embi_bus (.*);
  embi_mem_model u_embi_mem_model (.clock_i, .st_lo_n_i(low_lane_store_strobe_n_o),
    .st_hi_n_i(high_lane_store_strobe_n_o), .rd_n_i(read_strobe_n_o), .addr_i(addr_o),
    .wdata_i(data_o), .wait_i(wt), .rdata_o(data_i), .ready_o(ready_i));
  always #25 clock_i = ~clock_i;
  always @(posedge clock_i) begin
    if (addr_latch_o) ale_d <= data_o;
    sb <= sb & {read_strobe_n_o, high_lane_store_strobe_n_o, low_lane_store_strobe_n_o};
  end
  task chk(input string n, input logic [15:0] s, e);
    comparisons++;
    if (s !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // one access; returns once the master is idle again
  task acc(input logic w, input logic [23:0] a, input logic [15:0] d);
    int i;
    {req_valid_i, req_write_i, req_addr_i, req_wdata_i, sb} = {1'b1, w, a, d, 3'h7};
    while (req_ready_o !== 1'b1) @(posedge clock_i) #1;
    @(posedge clock_i) #1;
    req_valid_i = 0;
    for (i = 0; i < 20 && req_ready_o !== 1'b1; i++) begin
      @(posedge clock_i) #1;
      if (rsp_valid_o === 1'b1) rdata = rsp_rdata_o;
    end
  endtask : acc
  task close_out;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : close_out
  task t_split;
    acc(1, 24'h000010, 16'hA5C3); chk("even wr", sb, 3'h6);
    acc(1, 24'h000011, 16'h5A00); chk("odd wr", sb, 3'h5);
    wt = 3;
    acc(0, 24'h000010, 0); chk("rd strobe", sb, 3'h3);
    chk("rd data", rdata, 16'hA5C3);
    wt = 0;
    $display("split done");
  endtask : t_split
  task t_comb;
    combined_strobe_sel_i = 1;
    acc(1, 24'h400013, 16'h00C3); chk("comb odd", sb, 3'h4);
    acc(1, 24'h400012, 16'h0011); chk("comb even", sb, 3'h6);
    {combined_strobe_sel_i, byte_width_strap_i} = 2'b01;
    acc(1, 24'hC00021, 16'h0077); chk("byte wr", sb, 3'h4);
    acc(0, 24'hC00021, 0); chk("byte hi", rdata[15:8], 0);
    byte_width_strap_i = 0;
    $display("strobe schemes done");
  endtask : t_comb
  task t_mux;
    mux_bus_sel_i = 1;
    acc(0, 24'h801234, 0); chk("mux addr", ale_d, 16'h1234);
    mux_bus_sel_i = 0;
    $display("mux done");
  endtask : t_mux
  task t_hold;
    hold_req_n_i = 0;
    repeat (4) @(posedge clock_i) #1;
    chk("ack", bus_grant_ack_n_o, 0);
    chk("oe", {ctrl_oe_o, addr_oe_o, data_oe_o}, 0);
    chk("ready", req_ready_o, 0);
    hold_req_n_i = 1;
    repeat (2) @(posedge clock_i) #1;
    chk("ack off", bus_grant_ack_n_o, 1);
    $display("hold done");
  endtask : t_hold
  task t_single;
    {rst_n_i, boot_mode_strap_i} = 2'b00;
    repeat (3) @(posedge clock_i) #1;
    chk("in reset", {ctrl_oe_o, bus_grant_ack_n_o}, 1);
    rst_n_i = 1;
    repeat (3) @(posedge clock_i) #1;
    chk("single", {ext_mode_o, req_ready_o}, 0);
    $display("single chip done");
  endtask : t_single
  initial begin
    repeat (10) @(posedge clock_i);
    #1 rst_n_i = 1;
    repeat (2) @(posedge clock_i) #1;
    chk("ext mode", ext_mode_o, 1);
    t_split;
    t_comb;
    t_mux;
    t_hold;
    t_single;
    close_out;
  end
  initial begin
    #200000;
    fails++;
    close_out;
  end
endmodule : external_memory_bus_interface_tb_top
bind embi_bus embi_bus_properties u_embi_bus_properties (.*);
`default_nettype wire

// ---- verification/embi_mem_model.sv ----
// memory on the far side of the bus, with programmable wait states
`timescale 1ns/1ps
`default_nettype none
module embi_mem_model (
  input wire logic clock_i, st_lo_n_i, st_hi_n_i, rd_n_i,
  input wire logic [23:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic [3:0] wait_i,
  output logic [15:0] rdata_o,
  output logic ready_o
);
  logic [15:0] mem [256];
  logic [15:0] last = 0;
  logic [3:0] cnt = 0;
  always @(posedge clock_i) begin
    cnt <= (rd_n_i && st_lo_n_i && st_hi_n_i) ? 4'h0 : cnt + 4'h1;
    if (!(st_lo_n_i && st_hi_n_i) && rd_n_i) mem[addr_i[7:0]] <= wdata_i;
    if (!rd_n_i) last <= mem[addr_i[7:0]];
  end
  assign ready_o = cnt >= wait_i;
  // released lines show the inverse so stale data never passes
  assign rdata_o = rd_n_i ? ~last : mem[addr_i[7:0]];
endmodule : embi_mem_model
`default_nettype wire

// ---- verilog/embi_bus.sv ----
// external memory bus master: one access at a time from an internal request port
//
// Functional notes
// - space 3 uses a 16-bit data bus while the width strap is low, 8-bit while high.
// - separate bus carries data on the low lane, plus the high lane when 16 bits wide.
// - address bits 0 to 22 are driven true and bit 23 is driven inverted.
// - multiplexed bus shows address bits 0 to 7 on the low lane first, then data.
// - 16-bit multiplexed bus also shows address bits 8 to 15 on the high lane first.
// - four low-active chip selects, one per external space, asserted during its access.
// - split strobes on a 16-bit bus: low strobe writes even, high strobe writes odd.
// - the read strobe is low during reads and data is sampled while it is low.
// - combined scheme: one write strobe, odd lane enable low on odd addresses.
// - software picks the strobe scheme; the combined scheme is forced on an 8-bit bus.
// - an address latch pulse marks the address phase of every access.
// - the bus stays in hold for as long as the hold request input is low.
// - hold acknowledge is low for the whole hold state and high otherwise.
// - wait states are inserted while ready is low.
// - everything stays in reset while the reset input is low.
// - a grounded boot strap selects single-chip mode, no external accesses; hold is still acknowledged.
`timescale 1ns/1ps
`default_nettype none
`include "embi_map.svh"
module embi_bus
  import embi_pkg::*;
(
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // straps and mode
  input wire logic boot_mode_strap_i,
  input wire logic byte_width_strap_i,
  input wire logic combined_strobe_sel_i,
  input wire logic mux_bus_sel_i,
  // internal request port
  input wire logic req_valid_i,
  output logic req_ready_o,
  input wire logic req_write_i,
  input wire logic [`EMBI_ADDR_W-1:0] req_addr_i,
  input wire logic [`EMBI_DATA_W-1:0] req_wdata_i,
  output logic rsp_valid_o,
  output logic [`EMBI_DATA_W-1:0] rsp_rdata_o,
  output logic ext_mode_o,
  // bus arbitration and wait
  input wire logic hold_req_n_i,
  output logic bus_grant_ack_n_o,
  input wire logic ready_i,
  // address pins
  output logic [`EMBI_ADDR_W-1:0] addr_o,
  output logic addr_oe_o,
  // data pins, split into three signals
  input wire logic [`EMBI_DATA_W-1:0] data_i,
  output logic [`EMBI_DATA_W-1:0] data_o,
  output logic [1:0] data_oe_o,
  // control pins
  output logic [`EMBI_CS_N-1:0] space_select_n_o,
  output logic low_lane_store_strobe_n_o,
  output logic high_lane_store_strobe_n_o,
  output logic read_strobe_n_o,
  output logic addr_latch_o,
  output logic ctrl_oe_o
);
  typedef struct packed {
    embi_state_t st;
    logic ext;
    logic strap_seen;
    logic write;
    logic wide;
    logic combined;
    logic muxed;
    logic [`EMBI_ADDR_W-1:0] addr;
    logic [`EMBI_DATA_W-1:0] wdata;
    logic [`EMBI_DATA_W-1:0] rdata;
    logic rvalid;
    logic [`EMBI_CS_N-1:0] cs_n;
  } embi_regs_t;

  embi_regs_t s_q;
  embi_regs_t s_d;
  logic strobe;
  logic odd;
  logic wide_now;
  logic [`EMBI_CS_W-1:0] space_now;

  assign space_now = req_addr_i[`EMBI_CS_LSB +: `EMBI_CS_W];
  // only space 3 follows the width strap; others are fixed 16-bit
  assign wide_now = (space_now == `EMBI_SPACE_NARROW) ? !byte_width_strap_i : 1'b1;
  assign strobe = (s_q.st == ST_DATA);
  assign odd = s_q.addr[0];

  always_comb begin
    s_d = s_q;
    s_d.rvalid = 1'b0;
    // strap is caught once, on the first clock after reset release
    if (!s_q.strap_seen) begin
      s_d.strap_seen = 1'b1;
      s_d.ext = (boot_mode_strap_i != `EMBI_STRAP_SINGLE);
    end
    unique case (s_q.st)
      ST_IDLE: begin
        if (!hold_req_n_i) begin
          s_d.st = ST_HOLD;
        end else if (req_valid_i && s_q.ext) begin
          s_d.st = ST_ADDR;
          s_d.write = req_write_i;
          s_d.addr = req_addr_i;
          s_d.wdata = req_wdata_i;
          s_d.wide = wide_now;
          s_d.combined = combined_strobe_sel_i || !wide_now;
          s_d.muxed = mux_bus_sel_i;
          s_d.cs_n = ~(`EMBI_CS_N'(1) << space_now);
        end
      end
      ST_ADDR: begin
        s_d.st = ST_DATA;
      end
      ST_DATA: begin
        // ready low stretches the strobe phase
        if (ready_i) begin
          s_d.st = ST_DONE;
          s_d.rdata = s_q.wide ? data_i : {8'h00, data_i[7:0]};
          s_d.rvalid = !s_q.write;
        end
      end
      ST_DONE: begin
        // recovery cycle keeps selects valid past the strobe edge
        s_d.st = ST_IDLE;
        s_d.cs_n = {`EMBI_CS_N{1'b1}};
      end
      ST_HOLD: begin
        if (hold_req_n_i) begin
          s_d.st = ST_IDLE;
        end
      end
      default: begin
        s_d.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
      s_q.st <= ST_IDLE;
      s_q.cs_n <= {`EMBI_CS_N{1'b1}};
    end else begin
      s_q <= s_d;
    end
  end

  embi_lane_mux u_lane (
    .wide_i(s_q.wide),
    .combined_i(s_q.combined),
    .write_i(s_q.write),
    .odd_i(odd),
    .strobe_i(strobe),
    .rd_n_o(read_strobe_n_o),
    .wr_lo_n_o(low_lane_store_strobe_n_o),
    .wr_hi_n_o(high_lane_store_strobe_n_o)
  );

  always_comb begin
    addr_o = {~s_q.addr[`EMBI_TOP_BIT], s_q.addr[`EMBI_TOP_BIT-1:0]};
    data_o = s_q.wdata;
    data_oe_o = 2'h0;
    if (s_q.st == ST_ADDR && s_q.muxed) begin
      data_o = s_q.addr[`EMBI_DATA_W-1:0];
      data_oe_o = {s_q.wide, 1'b1};
    end else if (s_q.st == ST_DATA && s_q.write) begin
      data_oe_o = {s_q.wide, 1'b1};
    end
  end

  // pins float in hold and in single-chip mode
  assign addr_oe_o = s_q.ext && (s_q.st != ST_HOLD);
  assign ctrl_oe_o = s_q.ext && (s_q.st != ST_HOLD);
  assign space_select_n_o = s_q.cs_n;
  assign addr_latch_o = (s_q.st == ST_ADDR);
  assign bus_grant_ack_n_o = (s_q.st != ST_HOLD);
  assign req_ready_o = (s_q.st == ST_IDLE) && hold_req_n_i && s_q.ext;
  assign rsp_valid_o = s_q.rvalid;
  assign rsp_rdata_o = s_q.rdata;
  assign ext_mode_o = s_q.ext;
endmodule : embi_bus
`default_nettype wire

// ---- verilog/embi_lane_mux.sv ----
// byte lane steering and strobe decode for one access
`timescale 1ns/1ps
`default_nettype none
`include "embi_map.svh"
module embi_lane_mux (
  // access attributes
  input wire logic wide_i,
  input wire logic combined_i,
  input wire logic write_i,
  input wire logic odd_i,
  input wire logic strobe_i,
  // strobes, active low
  output logic rd_n_o,
  output logic wr_lo_n_o,
  output logic wr_hi_n_o
);
  always_comb begin
    rd_n_o = !(strobe_i && !write_i);
    if (combined_i || !wide_i) begin
      // single write strobe; high pin becomes the odd lane enable
      wr_lo_n_o = !(strobe_i && write_i);
      wr_hi_n_o = !(strobe_i && odd_i);
    end else begin
      wr_lo_n_o = !(strobe_i && write_i && !odd_i);
      wr_hi_n_o = !(strobe_i && write_i && odd_i);
    end
  end
endmodule : embi_lane_mux
`default_nettype wire

// ---- verilog/embi_map.svh ----
// constant map for the external memory bus interface
`ifndef EMBI_MAP_SVH
`define EMBI_MAP_SVH
`define EMBI_ADDR_W 24
`define EMBI_DATA_W 16
`define EMBI_CS_N 4
`define EMBI_CS_W 2
`define EMBI_TOP_BIT 23
`define EMBI_CS_LSB 22
`define EMBI_SPACE_NARROW 2'h3
`define EMBI_STRAP_SINGLE 1'h0
`define EMBI_ALE_CYCLES 2'h1
`endif

// ---- verilog/embi_pkg.sv ----
// types for the external memory bus interface
package embi_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_DATA = 3'b010,
    ST_DONE = 3'b011,
    ST_HOLD = 3'b100
  } embi_state_t;
endpackage : embi_pkg
